/* rtl/carrier_decode_pkg.sv */
// Constants for the carrier address decode front end
`default_nettype none
package carrier_decode_pkg;
    // Address modifiers
    localparam logic [5:0] AM_CFG      = 6'h2f;
    localparam logic [5:0] AM_SIO_SUP  = 6'h2d;
    localparam logic [5:0] AM_SIO_USR  = 6'h29;
    localparam logic [5:0] AM_STD_SUP  = 6'h3d;
    localparam logic [5:0] AM_STD_USR  = 6'h39;
    // Geographic slot limits
    localparam logic [4:0] SLOT_MIN    = 5'h01;
    localparam logic [4:0] SLOT_MAX    = 5'h15;
    // Configuration space is 512 KB, so slot number lands on A23..A19
    localparam int         CFG_BAR_LSB = 19;
    // Short I/O window is 1K bytes: compare A15..A10
    localparam int         SIO_BLK_LSB = 10;
    localparam int         SIO_BASE_W  = 6;
    // Configuration ROM window inside configuration space, and CSR window
    localparam logic [18:0] ROM_TOP    = 19'h00fff;
    localparam logic [18:0] CSR_BOT    = 19'h7fc00;
    // Module memory window compare on A23..A20 (1 MB granule)
    localparam int         MEM_LSB     = 20;
    // Module clock timing
    localparam int         CLK_HZ      = 40_000_000;
    localparam int         MOD_PER_NS  = 125;
    localparam int         MOD_PER_CYC = (MOD_PER_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int         BASE_CYC    = 2;
    // Bus interrupt level meaning none
    localparam logic [2:0] IRQ_LVL_NONE = 3'h0;
    localparam int         NMOD        = 4;
endpackage
`default_nettype wire

/* rtl/geo_slot_decode.sv */
// Geographic address capture: synchronise pins, check parity, form base
`default_nettype none
module geo_slot_decode (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [5:0]  ga_pin_n,
    output logic [4:0]       slot_r,
    output logic             slot_ok_r
);
    logic [5:0] ga_s1_r;
    logic [5:0] ga_s2_r;
    logic [4:0] num;
    logic       par_ok;

    // Two-stage synchroniser; undriven pins float high through pull-ups
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ga_s1_r <= 6'h3f;
            ga_s2_r <= 6'h3f;
        end else if (ce) begin
            ga_s1_r <= ga_pin_n;
            ga_s2_r <= ga_s1_r;
        end
    end

    // Grounded line means a one; parity line gives odd overall parity
    assign num    = ~ga_s2_r[4:0];
    assign par_ok = ^(~ga_s2_r);

    // Base value held in the configuration base address register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_r    <= 5'h00;
            slot_ok_r <= 1'b0;
        end else if (ce) begin
            slot_r    <= num;
            slot_ok_r <= par_ok && num >= carrier_decode_pkg::SLOT_MIN
                         && num <= carrier_decode_pkg::SLOT_MAX;
        end
    end

    // Grounded slot lines plus a grounded parity line must count odd
    slot_par_a: assert property (@(posedge clock) disable iff (!rst_n)
        ce && $past(ce) && slot_ok_r |-> ^{slot_r, ~$past(ga_s2_r[5])})
        else $error("slot accepted with bad parity");
endmodule
`default_nettype wire

/* rtl/carrier_decode.sv */
// Carrier address decode, configuration and interrupt pass-through
// How it works
// - Configuration space accesses with modifier 2F are answered from reset with no setup.
// - The configuration base comes from the geographic lines and is held in a register.
// - Geographic inputs idle high as if pulled up, so an open pin reads one.
// - The five slot lines form slot 1 to 21 and the parity line makes overall parity odd.
// - Reads of the ROM part of configuration space return board identity data.
// - Short I/O accesses are ignored after reset until software enables them.
// - Once enabled by the bit set register, short I/O answers modifier 29 or 2D as programmed.
// - The short I/O window covers carrier registers and module I/O and ID spaces.
// - The board takes exactly one 1K-byte block of short I/O space at the programmed base.
// - Module memory decoding starts disabled and is enabled by carrier registers.
// - With memory decoding enabled, standard accesses with modifier 39 or 3D are taken.
// - At reset all module interrupts are disabled and the bus level is none.
// - Only installed modules' requests are forwarded; the board raises none of its own.
// - A forwarded request stays until a clearing register access, not on acknowledge.
// - Each module wait state lengthens the transfer by one 125 ns module clock period.
`default_nettype none
module carrier_decode (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [5:0]  ga_pin_n,
    input  wire logic        as_pin_n,
    input  wire logic [5:0]  am_pin,
    input  wire logic [23:1] addr_pin,
    input  wire logic        write_pin_n,
    input  wire logic        iack_pin_n,
    input  wire logic        sio_ader_we,
    input  wire logic [5:0]  sio_base_in,
    input  wire logic        sio_am_sup_in,
    input  wire logic        sio_enable_set,
    input  wire logic        sio_enable_clr,
    input  wire logic        mem_enable_in,
    input  wire logic [3:0]  mem_base_in,
    input  wire logic [3:0]  irq_enable_in,
    input  wire logic [2:0]  irq_level_in,
    input  wire logic        irq_clear,
    input  wire logic [3:0]  mod_irq_pin_n,
    input  wire logic [3:0]  mod_present,
    input  wire logic [3:0]  mod_wait_in,
    output logic             sel_rom_r,
    output logic             sel_csr_r,
    output logic             sel_sio_r,
    output logic             sel_mem_r,
    output logic             ack_r,
    output logic [4:0]       cfg_bar_r,
    output logic             sio_enabled_r,
    output logic [6:0]       bus_irq_r
);
    typedef enum logic [1:0] {IDLE, WAITING, ACKED} xfer_t;

    logic [4:0]  slot_r;
    logic        slot_ok_r;
    logic        as_s1_r, as_s2_r, iack_s1_r, iack_s2_r, wr_s1_r, wr_s2_r;
    logic [5:0]  am_s1_r, am_s2_r;
    logic [23:1] ad_s1_r, ad_s2_r;
    logic [3:0]  irq_s1_r, irq_s2_r;
    logic [5:0]  sio_base_r;
    logic        sio_sup_r;
    logic        mem_en_r;
    logic [3:0]  mem_base_r, irq_en_r, pend_r;
    logic [2:0]  irq_lvl_r;
    xfer_t       st_r;
    logic [7:0]  cnt_r;
    logic        hit_cfg, hit_sio, hit_mem, in_rom, in_csr;
    logic [7:0]  wait_cyc;

    geo_slot_decode u_geo (
        .clock     (clock),
        .rst_n     (rst_n),
        .ce        (ce),
        .ga_pin_n  (ga_pin_n),
        .slot_r    (slot_r),
        .slot_ok_r (slot_ok_r)
    );

    // Bus pins come from another domain, so each passes two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            as_s1_r <= 1'b1; as_s2_r <= 1'b1;
            iack_s1_r <= 1'b1; iack_s2_r <= 1'b1;
            wr_s1_r <= 1'b1; wr_s2_r <= 1'b1;
            am_s1_r <= 6'h00; am_s2_r <= 6'h00;
            ad_s1_r <= 23'h000000; ad_s2_r <= 23'h000000;
            irq_s1_r <= 4'hf; irq_s2_r <= 4'hf;
        end else if (ce) begin
            as_s1_r <= as_pin_n; as_s2_r <= as_s1_r;
            iack_s1_r <= iack_pin_n; iack_s2_r <= iack_s1_r;
            wr_s1_r <= write_pin_n; wr_s2_r <= wr_s1_r;
            am_s1_r <= am_pin; am_s2_r <= am_s1_r;
            ad_s1_r <= addr_pin; ad_s2_r <= ad_s1_r;
            irq_s1_r <= mod_irq_pin_n; irq_s2_r <= irq_s1_r;
        end
    end

    // Configuration base register tracks the geographic slot
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) cfg_bar_r <= 5'h00;
        else if (ce) cfg_bar_r <= slot_ok_r ? slot_r : 5'h00;
    end

    // Short I/O compare register and enable, both cleared at reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sio_base_r    <= 6'h00;
            sio_sup_r     <= 1'b0;
            sio_enabled_r <= 1'b0;
        end else if (ce) begin
            if (sio_ader_we) begin
                sio_base_r <= sio_base_in;
                sio_sup_r  <= sio_am_sup_in;
            end
            if (sio_enable_set) sio_enabled_r <= 1'b1;
            else if (sio_enable_clr) sio_enabled_r <= 1'b0;
        end
    end

    // Carrier control: memory window and interrupt setup
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_en_r   <= 1'b0;
            mem_base_r <= 4'h0;
            irq_en_r   <= 4'h0;
            irq_lvl_r  <= carrier_decode_pkg::IRQ_LVL_NONE;
        end else if (ce) begin
            mem_en_r   <= mem_enable_in;
            mem_base_r <= mem_base_in;
            irq_en_r   <= irq_enable_in;
            irq_lvl_r  <= irq_level_in;
        end
    end

    // Address decode; acknowledge cycles are never decoded as accesses
    always_comb begin
        hit_cfg = (am_s2_r == carrier_decode_pkg::AM_CFG) && slot_ok_r
                  && ad_s2_r[23:carrier_decode_pkg::CFG_BAR_LSB] == slot_r;
        in_rom  = {ad_s2_r[18:1], 1'b0} <= carrier_decode_pkg::ROM_TOP;
        in_csr  = {ad_s2_r[18:1], 1'b0} >= carrier_decode_pkg::CSR_BOT;
        hit_sio = sio_enabled_r
                  && am_s2_r == (sio_sup_r ? carrier_decode_pkg::AM_SIO_SUP
                                           : carrier_decode_pkg::AM_SIO_USR)
                  && ad_s2_r[15:carrier_decode_pkg::SIO_BLK_LSB] == sio_base_r;
        hit_mem = mem_en_r
                  && (am_s2_r == carrier_decode_pkg::AM_STD_SUP
                      || am_s2_r == carrier_decode_pkg::AM_STD_USR)
                  && ad_s2_r[23:carrier_decode_pkg::MEM_LSB] == mem_base_r;
    end

    // Module accesses stretch by one module clock per wait state
    assign wait_cyc = 8'(carrier_decode_pkg::BASE_CYC
                      + carrier_decode_pkg::MOD_PER_CYC * int'(mod_wait_in));

    // Transfer sequencer: select, count out the access time, acknowledge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= IDLE; cnt_r <= 8'h00; ack_r <= 1'b0;
            sel_rom_r <= 1'b0; sel_csr_r <= 1'b0; sel_sio_r <= 1'b0; sel_mem_r <= 1'b0;
        end else if (ce) begin
            case (st_r)
                IDLE: begin
                    ack_r <= 1'b0;
                    if (!as_s2_r && iack_s2_r && (hit_cfg || hit_sio || hit_mem)) begin
                        sel_rom_r <= hit_cfg && in_rom && wr_s2_r;
                        sel_csr_r <= hit_cfg && in_csr;
                        sel_sio_r <= hit_sio;
                        sel_mem_r <= hit_mem;
                        cnt_r <= hit_cfg ? 8'(carrier_decode_pkg::BASE_CYC) : wait_cyc;
                        st_r <= WAITING;
                    end
                end
                WAITING: begin
                    // An early strobe release aborts; drop the selects so none lingers in IDLE
                    if (as_s2_r) begin
                        st_r      <= IDLE;
                        sel_rom_r <= 1'b0;
                        sel_csr_r <= 1'b0;
                        sel_sio_r <= 1'b0;
                        sel_mem_r <= 1'b0;
                    end else if (cnt_r <= 8'h01) begin
                        ack_r <= 1'b1;
                        st_r  <= ACKED;
                    end else cnt_r <= cnt_r - 8'h01;
                end
                ACKED: begin
                    if (as_s2_r) begin
                        ack_r <= 1'b0; st_r <= IDLE;
                        sel_rom_r <= 1'b0; sel_csr_r <= 1'b0;
                        sel_sio_r <= 1'b0; sel_mem_r <= 1'b0;
                    end
                end
                default: st_r <= IDLE;
            endcase
        end
    end

    // Pending requests latch; only a clearing access releases them, new requests win
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) pend_r <= 4'h0;
        else if (ce) pend_r <= (irq_clear ? 4'h0 : pend_r)
                                | (~irq_s2_r & mod_present & irq_en_r);
    end

    // Drive the programmed level only; no request originates here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) bus_irq_r <= 7'h00;
        else if (ce) begin
            bus_irq_r <= 7'h00;
            if (|pend_r && irq_lvl_r != carrier_decode_pkg::IRQ_LVL_NONE)
                bus_irq_r[irq_lvl_r - 3'h1] <= 1'b1;
        end
    end

    sio_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sio_enabled_r && st_r == IDLE && ce |=> !sel_sio_r)
        else $error("short I/O selected while disabled");
    cfg_take_a: assert property (@(posedge clock) disable iff (!rst_n)
        ce && st_r == IDLE && !as_s2_r && iack_s2_r && hit_cfg |=> st_r == WAITING)
        else $error("configuration access not taken");
    mem_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !mem_en_r && ce |=> !sel_mem_r || $past(sel_mem_r))
        else $error("memory selected while disabled");
    irq_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        ce && |pend_r && !irq_clear |=> |pend_r)
        else $error("pending request dropped without clear");
    irq_src_a: assert property (@(posedge clock) disable iff (!rst_n)
        ce && pend_r == 4'h0 |=> bus_irq_r == 7'h00)
        else $error("bus request without module source");
endmodule
`default_nettype wire

/* bench/vme_master_model.sv */
// Bus master model that runs single read or write transfers against the decode block
`default_nettype none
module vme_master_model (
    input  wire logic        clock,
    input  wire logic        ack_r,
    input  wire logic [3:0]  sel_in,
    output logic             as_pin_n,
    output logic [5:0]       am_pin,
    output logic [23:1]      addr_pin,
    output logic             write_pin_n,
    output logic             iack_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus: strobe high, read direction
    initial begin
        as_pin_n = 1'b1;
        am_pin = 6'h00;
        addr_pin = 23'h000000;
        write_pin_n = 1'b1;
        iack_pin_n = 1'b1;
    end
    // Strobe and qualifiers are held until ack is sampled high or the limit runs out
    task automatic access(input logic [5:0] am, input logic [23:1] a, input logic iack,
                          input logic wr_n,
                          input int lim, output logic hit, output logic [3:0] sel,
                          output int lat);
        hit = 1'b0;
        sel = 4'h0;
        lat = 0;
        @(posedge clock);
        as_pin_n <= 1'b0;
        am_pin <= am;
        addr_pin <= a;
        iack_pin_n <= iack;
        write_pin_n <= wr_n;
        while (!hit && lat < lim) begin
            @(posedge clock);
            lat++;
            hit = (ack_r === 1'b1);
            sel = sel_in;
        end
        // Released modifier and address lines show the inverse, so a stale value never passes for a drive
        as_pin_n <= 1'b1;
        am_pin <= ~am;
        addr_pin <= ~a;
        iack_pin_n <= 1'b1;
        write_pin_n <= 1'b1; // Direction line idles at read
        for (int i = 0; i < 12 && ack_r !== 1'b0; i++) @(posedge clock);
        @(posedge clock); // One idle cycle between transfers
    endtask
endmodule
`default_nettype wire

/* bench/test_carrier_decode.sv */
// Self-checking bench for the carrier address decode front end
`default_nettype none
module test_carrier_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, rst_n, ce, as_pin_n, write_pin_n, iack_pin_n, sio_ader_we;
    logic        sio_am_sup_in, sio_enable_set, sio_enable_clr, mem_enable_in, irq_clear;
    logic [5:0]  ga_pin_n, am_pin, sio_base_in;
    logic [23:1] addr_pin;
    logic [3:0]  mem_base_in, irq_enable_in, mod_irq_pin_n, mod_present, mod_wait_in;
    logic [2:0]  irq_level_in;
    logic        sel_rom_r, sel_csr_r, sel_sio_r, sel_mem_r, ack_r, sio_enabled_r;
    logic [4:0]  cfg_bar_r, s;
    logic [6:0]  bus_irq_r;
    int          bad_count, compares, lt, l0, l2;
    carrier_decode carrier_decode_i (.clock, .rst_n, .ce, .ga_pin_n, .as_pin_n, .am_pin,
        .addr_pin, .write_pin_n, .iack_pin_n, .sio_ader_we, .sio_base_in, .sio_am_sup_in,
        .sio_enable_set, .sio_enable_clr, .mem_enable_in, .mem_base_in, .irq_enable_in,
        .irq_level_in, .irq_clear, .mod_irq_pin_n, .mod_present, .mod_wait_in, .sel_rom_r,
        .sel_csr_r, .sel_sio_r, .sel_mem_r, .ack_r, .cfg_bar_r, .sio_enabled_r, .bus_irq_r);
    vme_master_model vme_master_model_i (.clock, .ack_r, .as_pin_n, .am_pin, .addr_pin,
        .sel_in({sel_mem_r, sel_sio_r, sel_csr_r, sel_rom_r}), .write_pin_n, .iack_pin_n);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Slot lines are active low; parity line grounded when the grounded count is even
    function automatic logic [5:0] ga_of(input logic [4:0] n);
        return {^n, ~n};
    endfunction
    task automatic do_reset(input logic [5:0] ga);
        rst_n <= 1'b0;
        ga_pin_n <= ga;
        repeat (20) @(posedge clock);
        chk("irq_rst", {1'b0, bus_irq_r}, 8'h00);
        chk("sio_rst", {7'h00, sio_enabled_r}, 8'h00);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
    task automatic xfer(input logic [5:0] am, input logic [23:1] a, input logic iack,
                        input logic eh, input logic [3:0] es, output int lat,
                        input logic wr_n = 1'b1);
        logic       hit;
        logic [3:0] sel;
        vme_master_model_i.access(am, a, iack, wr_n, eh ? 60 : 20, hit, sel, lat);
        chk("ack", {7'h00, hit}, {7'h00, eh});
        // The model's wait for ack to fall is bounded; a stuck ack counts here
        chk("ack_drop", {7'h00, ack_r}, 8'h00);
        if (eh) chk("sel", {4'h0, sel}, {4'h0, es});
        if (eh && hit !== 1'b1) give_verdict();
    endtask
    task automatic ader(input logic [5:0] b, input logic sup);
        @(posedge clock);
        sio_base_in <= b;
        sio_am_sup_in <= sup;
        sio_ader_we <= 1'b1;
        @(posedge clock);
        sio_ader_we <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic irq_chk(input logic [6:0] e);
        repeat (6) @(posedge clock);
        chk("bus_irq", {1'b0, bus_irq_r}, {1'b0, e});
    endtask
    // Main sequence
    initial begin
        {ce, rst_n} = 2'b10;
        {sio_ader_we, sio_am_sup_in, sio_enable_set, sio_enable_clr} = 4'h0;
        {mem_enable_in, irq_clear, irq_level_in, sio_base_in} = 11'h000;
        {mem_base_in, irq_enable_in, mod_present, mod_wait_in} = 16'h0000;
        {mod_irq_pin_n, ga_pin_n} = 10'h3ff;
        bad_count = 0;
        compares = 0;
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 5'h01 : (k == 1) ? 5'h15 : (k == 2) ? 5'h0a : 5'h16;
            do_reset(ga_of(s));
            chk("bar", {3'h0, cfg_bar_r}, (s >= carrier_decode_pkg::SLOT_MIN &&
                s <= carrier_decode_pkg::SLOT_MAX) ? {3'h0, s} : 8'h00);
        end
        do_reset(ga_of(5'h03) ^ 6'h20);
        chk("bar_par", {3'h0, cfg_bar_r}, 8'h00);
        do_reset(6'h3f);
        chk("bar_open", {3'h0, cfg_bar_r}, 8'h00);
        do_reset(ga_of(5'h05));
        xfer(carrier_decode_pkg::AM_CFG, {5'h05, 18'h00000}, 1'b1, 1, 4'h1, lt);
        xfer(carrier_decode_pkg::AM_CFG, {5'h05, 18'h3fe00}, 1'b1, 1, 4'h2, lt);
        // A write into the read-only ROM part is answered but selects nothing
        xfer(carrier_decode_pkg::AM_CFG, {5'h05, 18'h00010}, 1'b1, 1, 4'h0, lt, 1'b0);
        xfer(carrier_decode_pkg::AM_CFG, {5'h06, 18'h00000}, 1'b1, 0, 4'h0, lt);
        ader(6'h0c, 1'b1);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0c, 9'h000}, 1'b1, 0, 4'h0, lt);
        sio_enable_set <= 1'b1;
        @(posedge clock);
        sio_enable_set <= 1'b0;
        repeat (3) @(posedge clock);
        chk("sio_en", {7'h00, sio_enabled_r}, 8'h01);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0c, 9'h000}, 1'b1, 1, 4'h4, l0);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0c, 9'h1ff}, 1'b1, 1, 4'h4, lt);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0d, 9'h000}, 1'b1, 0, 4'h0, lt);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0b, 9'h1ff}, 1'b1, 0, 4'h0, lt);
        xfer(carrier_decode_pkg::AM_SIO_USR, {8'h00, 6'h0c, 9'h000}, 1'b1, 0, 4'h0, lt);
        mod_wait_in <= 4'h2;
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h0c, 9'h002}, 1'b1, 1, 4'h4, l2);
        chk("wait", 8'(l2 - l0), 8'(2 * carrier_decode_pkg::MOD_PER_CYC));
        mod_wait_in <= 4'h0;
        ader(6'h3f, 1'b0);
        xfer(carrier_decode_pkg::AM_SIO_USR, {8'h00, 6'h3f, 9'h100}, 1'b1, 1, 4'h4, lt);
        xfer(carrier_decode_pkg::AM_SIO_SUP, {8'h00, 6'h3f, 9'h100}, 1'b1, 0, 4'h0, lt);
        sio_enable_clr <= 1'b1;
        @(posedge clock);
        sio_enable_clr <= 1'b0;
        xfer(carrier_decode_pkg::AM_SIO_USR, {8'h00, 6'h3f, 9'h100}, 1'b1, 0, 4'h0, lt);
        xfer(carrier_decode_pkg::AM_STD_USR, {4'h3, 19'h00000}, 1'b1, 0, 4'h0, lt);
        mem_base_in <= 4'h3;
        mem_enable_in <= 1'b1;
        repeat (2) @(posedge clock);
        xfer(carrier_decode_pkg::AM_STD_USR, {4'h3, 19'h12345}, 1'b1, 1, 4'h8, lt);
        xfer(carrier_decode_pkg::AM_STD_SUP, {4'h3, 19'h7ffff}, 1'b1, 1, 4'h8, lt);
        xfer(carrier_decode_pkg::AM_STD_SUP, {4'h4, 19'h00000}, 1'b1, 0, 4'h0, lt);
        // Module 0 present and requesting, level three, enables still off
        mod_present <= 4'h1;
        irq_level_in <= 3'h3;
        mod_irq_pin_n <= 4'he;
        irq_chk(7'h00);
        irq_enable_in <= 4'hf;
        irq_chk(7'h04);
        mod_irq_pin_n <= 4'hf;
        xfer(carrier_decode_pkg::AM_CFG, {5'h05, 18'h00000}, 1'b0, 0, 4'h0, lt);
        irq_chk(7'h04);
        // Clock enable low freezes the pending request, so a clear pulse then is ignored
        ce <= 1'b0;
        irq_clear <= 1'b1;
        @(posedge clock);
        irq_clear <= 1'b0;
        repeat (2) @(posedge clock);
        ce <= 1'b1;
        irq_chk(7'h04);
        irq_clear <= 1'b1;
        @(posedge clock);
        irq_clear <= 1'b0;
        irq_chk(7'h00);
        mod_irq_pin_n <= 4'hd;
        irq_chk(7'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
